// ==== shared/dlvc_pkg.sv ====
/*
 * Constants and carrier types for the display serial to LVDS bridge core.
 * Assumes one system clock at the rate given here and byte-wide registers.
 */
package dlvc_pkg;

  // ---------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_RESTART = 8'h09;
  localparam logic [7:0] ADDR_CLKSRC = 8'h0A;
  localparam logic [7:0] ADDR_RATIO = 8'h0B;
  localparam logic [7:0] ADDR_PLL = 8'h0D;
  localparam logic [7:0] ADDR_INMODE = 8'h10;
  localparam logic [7:0] ADDR_INBAND = 8'h12;
  localparam logic [7:0] ADDR_OUTFMT = 8'h18;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int RESTART_BIT = 0;
  localparam int CLKSRC_BIT = 0;
  localparam int LOCK_BIT = 7;
  localparam int OBAND_LSB = 1;
  localparam int OBAND_MSB = 3;
  localparam int MULT_LSB = 0;
  localparam int MULT_MSB = 1;
  localparam int DIV_LSB = 3;
  localparam int DIV_MSB = 7;
  localparam int PLLEN_BIT = 0;
  localparam int SPLIT_BIT = 7;
  localparam int CHMODE_LSB = 5;
  localparam int CHMODE_MSB = 6;
  localparam int LANES_LSB = 3;
  localparam int LANES_MSB = 4;
  localparam int LINK_BIT = 4;
  localparam int A_WIDE_BIT = 3;
  localparam int B_WIDE_BIT = 2;
  localparam int A_LAYOUT_BIT = 1;
  localparam int B_LAYOUT_BIT = 0;

  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  localparam logic LINK_SINGLE = 1'b1;
  localparam logic SRC_DSI = 1'b1;
  localparam logic [1:0] CHMODE_A = 2'h0;
  localparam logic [1:0] LANES_FOUR = 2'h0;

  // ---------------------------------------------------------------------
  // Timing and sizes
  // ---------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int PLL_LOCK_NS = 1000;
  localparam int PLL_LOCK_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) /
                                CLK_PERIOD_NS;
  localparam int LOCK_CNT_W = 5;
  localparam int LANE_MAX = 4;
  localparam int ACC_BYTES = 8;
  localparam int PIX_BYTES = 3;
  localparam int ACC_CNT_W = 4;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_WAIT_LOCK = 4'h2,
    ST_LOCKED = 4'h4,
    ST_RUN = 4'h8
  } dlvc_state_t;

  typedef struct packed {
    logic valid;
    logic [LANE_MAX-1:0][7:0] data;
  } dlvc_lanes_t;

  typedef struct packed {
    logic [2:0] count;
    logic [LANE_MAX-1:0][7:0] data;
  } dlvc_merged_t;

  typedef struct packed {
    logic hs;
    logic vs;
  } dlvc_sync_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dlvc_reg_req_t;

  typedef struct packed {
    logic on;
    logic src_dsi;
    logic [1:0] mult;
    logic [4:0] div;
    logic [2:0] out_band;
    logic [7:0] in_band;
  } dlvc_pll_cfg_t;

  typedef struct packed {
    logic clk_on;
    logic [3:0] pair_on;
    logic [3:0][6:0] pair;
  } dlvc_chan_t;

endpackage : dlvc_pkg

// ==== core/dlvc_lane_merge.sv ====
/*
 * Lane merger: gathers the bytes of the active high-speed data lanes,
 * lane 0 first, into one registered group with a byte count.
 * Assumes lanes arrive bit and byte aligned on the system clock.
 */
`timescale 1ns/100ps
module dlvc_lane_merge (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic [1:0] lane_cfg,
  input wire dlvc_pkg::dlvc_lanes_t lanes,
  output dlvc_pkg::dlvc_merged_t merged
);
  import dlvc_pkg::*;

  typedef struct packed {
    dlvc_merged_t out;
  } dlvc_lm_state_t;

  dlvc_lm_state_t cur;
  dlvc_lm_state_t next_cur;

  // -----------------------------------------------------------------------
  // Lane count decode
  // -----------------------------------------------------------------------
  // Code zero means four lanes so the reset value gives the widest link.
  function automatic logic [2:0] lanes_used(input logic [1:0] code);
    lanes_used = (code == LANES_FOUR) ? 3'(LANE_MAX) : {1'b0, code};
  endfunction : lanes_used

  always_comb begin
    next_cur = cur;
    next_cur.out.count = 3'h0;
    next_cur.out.data = '0;
    if (!clr && lanes.valid) begin
      next_cur.out.count = lanes_used(lane_cfg); // RULE20
      for (int i = 0; i < LANE_MAX; i++) begin
        if (3'(i) < lanes_used(lane_cfg)) begin
          next_cur.out.data[i] = lanes.data[i]; // RULE21
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign merged = cur.out;

endmodule : dlvc_lane_merge

// ==== core/dlvc_top.sv ====
/*
 * Bridge core: configuration registers, PLL control and lock tracking,
 * pixel assembly from merged lane bytes, and LVDS channel word mapping.
 * Assumes a register port already decoded from the serial management
 * interface, an analog PLL and serialisers outside that act on pll_cfg
 * and the channel words, and a packet layer that supplies sync status.
 */
// Function
// RULE1 - Enable low holds everything in reset and outputs undriven.
// RULE2 - Controller keeps enable low at least 10 ms to reset.
// RULE3 - Host keeps all lanes at LP11 during reset.
// RULE4 - Controller waits 1 ms after enable before configuring.
// RULE5 - Nothing runs until software programs the configuration.
// RULE6 - Bring-up: stream, PLL on, poll lock, then logic restart.
// RULE7 - Clock source bit picks DSI clock lane or external reference.
// RULE8 - Host runs the clock lane continuously when it is the source.
// RULE9 - External reference is multiplied by the multiplier field.
// RULE10 - External reference lies between 25 and 154 MHz.
// RULE11 - DSI clock is divided by the divider field.
// RULE12 - Software sets both clock bands before enabling the PLL.
// RULE13 - Link bit: one gives single link, zero odd/even dual link.
// RULE14 - Split bit and channel field shape mode; 18 and 24 bit pixels.
// RULE15 - Idle pixels are zero while sync status keeps flowing.
// RULE16 - Layout bit per channel; second layout puts MSBs on pair 3.
// RULE17 - First layout puts the two LSBs of each colour on pair 3.
// RULE18 - Layout one with narrow mode drops pair 3 and the LSBs.
// RULE19 - Single link holds channel B clock and data low.
// RULE20 - Four lanes by default, one to three selectable.
// RULE21 - Bytes of active lanes merge into the video stream.
// RULE22 - Unused lanes stay unconnected or at LP11.
// RULE23 - After lock channel A clock and pairs 0-2 start; others wait.
// RULE24 - Lock flag is read only and clears when the PLL stops.
`timescale 1ns/100ps
module dlvc_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic en,
  input wire dlvc_pkg::dlvc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire dlvc_pkg::dlvc_lanes_t lanes,
  input wire logic pixel_18bpp,
  input wire dlvc_pkg::dlvc_sync_t sync_in,
  input wire logic dsi_clk_active,
  input wire logic ext_ref_active,
  output dlvc_pkg::dlvc_pll_cfg_t pll_cfg,
  output dlvc_pkg::dlvc_chan_t chan_a,
  output dlvc_pkg::dlvc_chan_t chan_b,
  output logic lvds_oe
);
  import dlvc_pkg::*;

  typedef struct packed {
    dlvc_state_t st;
    logic [7:0] clksrc;
    logic [7:0] ratio;
    logic [7:0] pll;
    logic [7:0] inmode;
    logic [7:0] inband;
    logic [7:0] outfmt;
    logic [LOCK_CNT_W-1:0] lock_cnt;
    logic [ACC_BYTES-1:0][7:0] acc;
    logic [ACC_CNT_W-1:0] acc_cnt;
    logic [7:0] rdata;
    dlvc_pll_cfg_t pcfg;
    dlvc_chan_t a;
    dlvc_chan_t b;
    logic oe;
  } dlvc_top_state_t;

  dlvc_top_state_t cur;
  dlvc_top_state_t next_cur;
  dlvc_merged_t merged;

  // -----------------------------------------------------------------------
  // Lane merging
  // -----------------------------------------------------------------------
  dlvc_lane_merge u_merge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clr(cur.st != ST_RUN),
    .lane_cfg(cur.inmode[LANES_MSB:LANES_LSB]),
    .lanes(lanes),
    .merged(merged)
  );

  // -----------------------------------------------------------------------
  // Channel word mapping
  // -----------------------------------------------------------------------
  // Pairs 0 to 2 always carry six bits per colour plus the strobes; pair 3
  // carries the other two bits, low ones in layout one, high ones else.
  function automatic logic [3:0][6:0] map_pairs(
    input logic [23:0] px,
    input logic pixel_valid_strobe,
    input dlvc_sync_t s,
    input logic lsb_on_p3,
    input logic p3_on
  );
    logic [5:0] r6;
    logic [5:0] g6;
    logic [5:0] b6;
    logic [5:0] x2;
    r6 = lsb_on_p3 ? px[23:18] : px[21:16]; // RULE16
    g6 = lsb_on_p3 ? px[15:10] : px[13:8];
    b6 = lsb_on_p3 ? px[7:2] : px[5:0];
    x2 = lsb_on_p3 ? {px[1:0], px[9:8], px[17:16]} // RULE17
                   : {px[7:6], px[15:14], px[23:22]}; // RULE16
    map_pairs[0] = {g6[0], r6};
    map_pairs[1] = {b6[1:0], g6[5:1]};
    map_pairs[2] = {pixel_valid_strobe, s.vs, s.hs, b6[5:2]};
    map_pairs[3] = p3_on ? {1'b0, x2} : 7'h00; // RULE18
  endfunction : map_pairs

  // Loosely packed 18 bit pixels sit in the top six bits of each byte.
  function automatic logic [23:0] pixel_of(
    input logic [2:0][7:0] b,
    input logic narrow
  );
    logic [23:0] mask;
    mask = narrow ? 24'hFCFCFC : 24'hFFFFFF; // RULE14
    pixel_of = {b[0], b[1], b[2]} & mask;
  endfunction : pixel_of

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    logic pll_ok;
    logic locked;
    logic dual;
    logic running;
    logic restart;
    logic have;
    logic [ACC_CNT_W-1:0] need;
    logic [ACC_CNT_W-1:0] base;
    logic [23:0] px_odd;
    logic [23:0] px_even;
    logic [23:0] px_a;
    logic [23:0] px_b;
    logic [ACC_BYTES-1:0][7:0] shifted;
    logic [7:0] rd;
    pll_ok = 1'b0;
    locked = 1'b0;
    dual = 1'b0;
    running = 1'b0;
    restart = 1'b0;
    have = 1'b0;
    need = '0;
    base = '0;
    px_odd = '0;
    px_even = '0;
    px_a = '0;
    px_b = '0;
    shifted = '0;
    rd = 8'h00;
    next_cur = cur;

    // ---------------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------------
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_RESTART: restart = reg_req.wdata[RESTART_BIT]; // RULE6
        ADDR_CLKSRC: next_cur.clksrc = reg_req.wdata;
        ADDR_RATIO: next_cur.ratio = reg_req.wdata;
        ADDR_PLL: next_cur.pll = reg_req.wdata;
        ADDR_INMODE: next_cur.inmode = reg_req.wdata;
        ADDR_INBAND: next_cur.inband = reg_req.wdata;
        ADDR_OUTFMT: next_cur.outfmt = reg_req.wdata;
        default: restart = 1'b0;
      endcase
    end

    // ---------------------------------------------------------------------
    // PLL lock tracking
    // ---------------------------------------------------------------------
    // The lock timer restarts whenever the chosen source stops, so a
    // source loss forces a fresh lock before video resumes.
    pll_ok = cur.pll[PLLEN_BIT] &&
             ((cur.clksrc[CLKSRC_BIT] == SRC_DSI) ? dsi_clk_active
                                                  : ext_ref_active); // RULE7
    if (!pll_ok) begin
      next_cur.lock_cnt = '0; // RULE24
    end else if (cur.lock_cnt != LOCK_CNT_W'(PLL_LOCK_CYC)) begin
      next_cur.lock_cnt = cur.lock_cnt + LOCK_CNT_W'(1);
    end
    locked = pll_ok && (cur.lock_cnt == LOCK_CNT_W'(PLL_LOCK_CYC));

    case (cur.st)
      ST_OFF: next_cur.st = ST_WAIT_LOCK;
      ST_WAIT_LOCK: next_cur.st = locked ? ST_LOCKED : ST_WAIT_LOCK;
      ST_LOCKED: begin
        if (!locked) begin
          next_cur.st = ST_WAIT_LOCK; // RULE24
        end else if (restart) begin
          next_cur.st = ST_RUN; // RULE5
        end
      end
      ST_RUN: next_cur.st = locked ? ST_RUN : ST_WAIT_LOCK;
      default: next_cur.st = ST_OFF;
    endcase

    next_cur.pcfg.on = cur.pll[PLLEN_BIT]; // RULE12
    next_cur.pcfg.src_dsi = cur.clksrc[CLKSRC_BIT]; // RULE7
    next_cur.pcfg.mult = cur.ratio[MULT_MSB:MULT_LSB]; // RULE9
    next_cur.pcfg.div = cur.ratio[DIV_MSB:DIV_LSB]; // RULE11
    next_cur.pcfg.out_band = cur.clksrc[OBAND_MSB:OBAND_LSB];
    next_cur.pcfg.in_band = cur.inband;

    // ---------------------------------------------------------------------
    // Pixel assembly
    // ---------------------------------------------------------------------
    dual = cur.outfmt[LINK_BIT] != LINK_SINGLE; // RULE13
    running = (cur.st == ST_RUN) &&
              (cur.inmode[CHMODE_MSB:CHMODE_LSB] == CHMODE_A); // RULE14
    need = dual ? ACC_CNT_W'(2 * PIX_BYTES) : ACC_CNT_W'(PIX_BYTES);
    have = running && (cur.acc_cnt >= need);
    px_odd = pixel_of(cur.acc[2:0], pixel_18bpp);
    px_even = pixel_of(cur.acc[5:3], pixel_18bpp);
    shifted = have ? (cur.acc >> (8 * int'(need))) : cur.acc;
    base = have ? (cur.acc_cnt - need) : cur.acc_cnt;
    // Bytes that find no room are dropped: the link must drain at least
    // as fast as the lanes deliver, there is no stall toward the host.
    for (int i = 0; i < LANE_MAX; i++) begin
      if (3'(i) < merged.count && (int'(base) + i) < ACC_BYTES) begin
        shifted[int'(base) + i] = merged.data[i]; // RULE21
      end
    end
    next_cur.acc = shifted;
    next_cur.acc_cnt = ACC_CNT_W'(((int'(base) + int'(merged.count)) >
                                   ACC_BYTES) ? ACC_BYTES
                                  : (int'(base) + int'(merged.count)));
    if (!running || restart) begin
      next_cur.acc = '0; // RULE6
      next_cur.acc_cnt = '0;
    end

    // Split swaps which channel takes the first pixel of each pair.
    px_a = cur.inmode[SPLIT_BIT] ? px_even : px_odd;
    px_b = cur.inmode[SPLIT_BIT] ? px_odd : px_even;
    if (!have) begin
      px_a = '0; // RULE15
      px_b = '0;
    end

    // ---------------------------------------------------------------------
    // LVDS channel words
    // ---------------------------------------------------------------------
    next_cur.a.clk_on = (cur.st == ST_LOCKED) || (cur.st == ST_RUN);
    next_cur.a.pair_on = {next_cur.a.clk_on && cur.outfmt[A_WIDE_BIT],
                          {3{next_cur.a.clk_on}}}; // RULE23
    next_cur.a.pair = map_pairs(px_a, have, sync_in, // RULE15
                                cur.outfmt[A_LAYOUT_BIT],
                                next_cur.a.pair_on[3]);
    next_cur.b.clk_on = next_cur.a.clk_on && dual; // RULE19
    next_cur.b.pair_on = {next_cur.b.clk_on && cur.outfmt[B_WIDE_BIT],
                          {3{next_cur.b.clk_on}}}; // RULE23
    next_cur.b.pair = next_cur.b.clk_on
                      ? map_pairs(px_b, have, sync_in,
                                  cur.outfmt[B_LAYOUT_BIT],
                                  next_cur.b.pair_on[3])
                      : '0; // RULE19
    next_cur.oe = 1'b1;

    // ---------------------------------------------------------------------
    // Register reads
    // ---------------------------------------------------------------------
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_RESTART: rd = 8'h00;
        ADDR_CLKSRC: begin
          rd = cur.clksrc;
          rd[LOCK_BIT] = locked; // RULE24
        end
        ADDR_RATIO: rd = cur.ratio;
        ADDR_PLL: rd = cur.pll;
        ADDR_INMODE: rd = cur.inmode;
        ADDR_INBAND: rd = cur.inband;
        ADDR_OUTFMT: rd = cur.outfmt;
        default: rd = 8'h00;
      endcase
    end
    next_cur.rdata = rd;

    // Enable low forces every field to its reset value, which also
    // ignores register requests and lane input while it lasts.
    if (!en) begin
      next_cur = '0; // RULE1
      next_cur.st = ST_OFF;
      next_cur.clksrc = CFG_RESET;
      next_cur.ratio = CFG_RESET;
      next_cur.pll = CFG_RESET;
      next_cur.inmode = CFG_RESET;
      next_cur.inband = CFG_RESET;
      next_cur.outfmt = CFG_RESET;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cur <= '0;
      cur.st <= ST_OFF;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign pll_cfg = cur.pcfg;
  assign chan_a = cur.a;
  assign chan_b = cur.b;
  assign lvds_oe = cur.oe; // RULE1

endmodule : dlvc_top

// ==== dv/dlvc_top_properties.sv ====
/* Checker of dlvc_top port relations over time.
   Assumes a bind to dlvc_top, one clock and async active-low reset. */
`timescale 1ns/100ps
module dlvc_top_checker (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic en,
  input wire dlvc_pkg::dlvc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire dlvc_pkg::dlvc_lanes_t lanes,
  input wire dlvc_pkg::dlvc_sync_t sync_in,
  input wire logic dsi_clk_active,
  input wire logic ext_ref_active,
  input wire dlvc_pkg::dlvc_pll_cfg_t pll_cfg,
  input wire dlvc_pkg::dlvc_chan_t chan_a,
  input wire dlvc_pkg::dlvc_chan_t chan_b,
  input wire logic lvds_oe
);
  import dlvc_pkg::*;
  // --------
  // Format shadow
  // --------
  logic [7:0] fmt;
  // Cleared by enable low as well, the same way the design's copy is.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fmt <= 8'h00;
    end else if (!en) begin
      fmt <= 8'h00;
    end else if (reg_req.wr && reg_req.addr == ADDR_OUTFMT) begin
      fmt <= reg_req.wdata;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_off_quiet: assert property (
    !en |=> !lvds_oe && chan_a == '0 && chan_b == '0 && pll_cfg == '0)
    else $error("outputs active while disabled");
  a_oe_on: assert property (en |=> lvds_oe)
    else $error("output enable missing");
  a_lock_nosrc: assert property (
    (!dsi_clk_active && !ext_ref_active)[*2] ##0
    (en && reg_req.rd && reg_req.addr == ADDR_CLKSRC)
    |=> !reg_rdata[LOCK_BIT]) else $error("lock without source");
  a_lock_early: assert property (
    $rose(pll_cfg.on) ##[0:10]
    (en && reg_req.rd && reg_req.addr == ADDR_CLKSRC)
    |=> !reg_rdata[LOCK_BIT]) else $error("lock too early");
  a_idle_zero: assert property (
    !lanes.valid [*8] |-> chan_a.pair[0] == 7'h00 && !chan_a.pair[2][6])
    else $error("pixel data while idle");
  a_sync_pass: assert property (
    chan_a.clk_on && $past(chan_a.clk_on) |->
    chan_a.pair[2][5:4] == $past({sync_in.vs, sync_in.hs}))
    else $error("sync status lost");
  a_base_pairs: assert property (
    chan_a.pair_on[2:0] == {3{chan_a.clk_on}})
    else $error("base pairs not tied to clock");
  a_p3_narrow: assert property (
    !fmt[A_WIDE_BIT] [*3] |-> !chan_a.pair_on[3] && chan_a.pair[3] == 7'h00)
    else $error("fourth pair active in narrow mode");
  a_b_single: assert property (
    fmt[LINK_BIT] [*3] |-> chan_b == '0)
    else $error("channel B active in single link");
endmodule : dlvc_top_checker
bind dlvc_top dlvc_top_checker chk_u (.sys_clk(sys_clk), .rstn(rstn),
  .en(en), .reg_req(reg_req), .reg_rdata(reg_rdata), .lanes(lanes),
  .sync_in(sync_in), .dsi_clk_active(dsi_clk_active),
  .ext_ref_active(ext_ref_active), .pll_cfg(pll_cfg), .chan_a(chan_a),
  .chan_b(chan_b), .lvds_oe(lvds_oe));

// ==== dv/dlvc_host_model.sv ====
/* Host model driving the video lanes, sync status and clock lane state.
   Assumes the bench asks for one pixel per cycle on lanes 0 to 2. */
`timescale 1ns/100ps
module dlvc_host_model (
  input wire logic sys_clk,
  input wire logic en,
  input wire logic clk_run,
  input wire logic send,
  input wire logic [23:0] px,
  output dlvc_pkg::dlvc_lanes_t lanes,
  output dlvc_pkg::dlvc_sync_t sync_in,
  output logic dsi_clk_active
);
  import dlvc_pkg::*;
  logic [7:0] tick = 8'h00;
  // Lane 3 carries a changing pattern so a wrong lane count shows up.
  always @(posedge sys_clk) begin
    tick <= tick + 8'h01;
    sync_in <= {tick[6:0] == 7'h00, tick[2:0] == 3'h0};
    dsi_clk_active <= clk_run;
    lanes.valid <= send && en;
    lanes.data <= {tick ^ 8'hA5, send ? px[7:0] : ~tick,
      send ? px[15:8] : tick, send ? px[23:16] : ~tick};
  end
endmodule : dlvc_host_model

// ==== dv/tb.sv ====
/* Self-checking bench of dlvc_top with a host lane model.
   Assumes notes of expected values are compared by the monitor. */
`timescale 1ns/100ps
module tb;
  import dlvc_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic en = 1'b0;
  logic clk_run = 1'b1;
  logic ext_ref_active = 1'b0;
  logic pixel_18bpp = 1'b0;
  logic send = 1'b0;
  logic [23:0] px = 24'h000000;
  logic rd_chk = 1'b0;
  logic split = 1'b0;
  logic [7:0] fmt = 8'h00;
  logic [7:0] r1;
  logic [7:0] r2;
  logic [7:0] addrs[8] = '{ADDR_RESTART, ADDR_CLKSRC, ADDR_RATIO,
    ADDR_PLL, ADDR_INMODE, ADDR_INBAND, ADDR_OUTFMT, 8'h55};
  logic [7:0] fmts[4] = '{8'h1A, 8'h18, 8'h12, 8'h0D};
  dlvc_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  dlvc_lanes_t lanes;
  dlvc_sync_t sync_in;
  logic dsi_clk_active;
  dlvc_pll_cfg_t pll_cfg;
  dlvc_chan_t chan_a;
  dlvc_chan_t chan_b;
  logic lvds_oe;
  int err_count = 0;
  int total_checks = 0;
  logic [7:0] reg_q[$];
  logic [23:0] a_q[$];
  logic [23:0] b_q[$];
  initial forever #(CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
  dlvc_top dut_u (.sys_clk(sys_clk), .rstn(rstn), .en(en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .lanes(lanes),
    .pixel_18bpp(pixel_18bpp), .sync_in(sync_in),
    .dsi_clk_active(dsi_clk_active), .ext_ref_active(ext_ref_active),
    .pll_cfg(pll_cfg), .chan_a(chan_a), .chan_b(chan_b),
    .lvds_oe(lvds_oe));
  dlvc_host_model host_u (.sys_clk(sys_clk), .en(en), .clk_run(clk_run),
    .send(send), .px(px), .lanes(lanes), .sync_in(sync_in),
    .dsi_clk_active(dsi_clk_active));
  // --------
  // Tasks
  // --------
  task automatic check(input string what, input logic [25:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  function automatic logic [25:0] words(input logic [23:0] p,
      input logic lay, input logic wide);
    logic [5:0] c6[3];
    logic [1:0] cx[3];
    logic [7:0] k;
    for (int i = 0; i < 3; i++) begin
      k = p[23-8*i -: 8] & {6'h3F, {2{!pixel_18bpp}}};
      {c6[i], cx[i]} = lay ? k : {k[5:0], k[7:6]};
    end
    return {wide ? {1'b0, cx[2], cx[1], cx[0]} : 7'h00, 1'b1, c6[2][5:2],
      c6[2][1:0], c6[1][5:1], c6[1][0], c6[0]};
  endfunction : words
  task automatic chk_px(input dlvc_chan_t c, ref logic [23:0] q[$],
      input logic lay, input logic wide);
    logic [25:0] exp;
    exp = 26'h0;
    if (q.size() > 0) exp = words(q.pop_front(), lay, wide);
    check("pixel", {c.pair[3], c.pair[2][6], c.pair[2][3:0], c.pair[1],
      c.pair[0]}, exp);
  endtask : chk_px
  // A read notes its expected value; a write to the format register also updates the shadow.
  task automatic acc(input logic w, input logic [7:0] a, d);
    if (!w) reg_q.push_back(d);
    if (w && a == ADDR_OUTFMT) fmt = d;
    @(posedge sys_clk);
    reg_req <= {w, !w, a, w ? d : 8'h00};
    @(posedge sys_clk);
    reg_req <= '0;
    @(negedge sys_clk);
  endtask : acc
  task automatic pixels(input int n);
    logic [23:0] v;
    for (int i = 0; i < n; i++) begin
      v = 24'($urandom);
      @(posedge sys_clk);
      send <= 1'b1;
      px <= v;
      if (!fmt[LINK_BIT] && (i[0] ^ split)) b_q.push_back(v);
      else a_q.push_back(v);
    end
    @(posedge sys_clk);
    send <= 1'b0;
    for (int k = 0; k < 30 && a_q.size() + b_q.size() > 0; k++)
      @(posedge sys_clk);
    if (a_q.size() + b_q.size() > 0) begin
      err_count++;
      finish_test();
    end
  endtask : pixels
  // --------
  // Monitor
  // --------
  always @(posedge sys_clk) rd_chk <= en && reg_req.rd;
  always @(negedge sys_clk) begin
    if (rd_chk && reg_q.size() > 0)
      check("reg_rdata", {18'h0, reg_rdata}, {18'h0, reg_q.pop_front()});
    if (chan_a.pair[2][6])
      chk_px(chan_a, a_q, fmt[A_LAYOUT_BIT], fmt[A_WIDE_BIT]);
    if (chan_b.pair[2][6])
      chk_px(chan_b, b_q, fmt[B_LAYOUT_BIT], fmt[B_WIDE_BIT]);
  end
  // --------
  // Sequence
  // --------
  initial begin
    void'($urandom(32'hA7BB));
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    en <= 1'b1;
    repeat (20000) @(posedge sys_clk);
    acc(1'b1, 8'h55, 8'hFF);
    foreach (addrs[i]) acc(1'b0, addrs[i], CFG_RESET);
    $display("test reset values done");
    r1 = 8'($urandom);
    r2 = 8'($urandom);
    acc(1'b1, ADDR_RATIO, r1);
    acc(1'b1, ADDR_INBAND, r2);
    acc(1'b1, ADDR_CLKSRC, 8'h8B);
    acc(1'b0, ADDR_CLKSRC, 8'h0B);
    check("pll_cfg", {2'h0, pll_cfg},
      {3'h1, r1[1:0], r1[7:3], 3'h5, r2});
    acc(1'b1, ADDR_CLKSRC, 8'h0A);
    acc(1'b1, ADDR_INMODE, 8'h18);
    acc(1'b1, ADDR_PLL, 8'h01);
    repeat (5) @(posedge sys_clk);
    acc(1'b0, ADDR_CLKSRC, 8'h0A);
    repeat (PLL_LOCK_CYC + 2) @(posedge sys_clk);
    acc(1'b0, ADDR_CLKSRC, 8'h0A);
    @(posedge sys_clk);
    ext_ref_active <= 1'b1;
    repeat (PLL_LOCK_CYC + 2) @(posedge sys_clk);
    acc(1'b0, ADDR_CLKSRC, 8'h8A);
    @(posedge sys_clk);
    ext_ref_active <= 1'b0;
    clk_run <= 1'b0;
    repeat (3) @(posedge sys_clk);
    acc(1'b0, ADDR_CLKSRC, 8'h0A);
    @(posedge sys_clk);
    ext_ref_active <= 1'b1;
    clk_run <= 1'b1;
    repeat (PLL_LOCK_CYC + 2) @(posedge sys_clk);
    acc(1'b0, ADDR_CLKSRC, 8'h8A);
    acc(1'b1, ADDR_RESTART, 8'h01);
    acc(1'b0, ADDR_RESTART, 8'h00);
    $display("test clock and lock done");
    foreach (fmts[i]) begin
      acc(1'b1, ADDR_OUTFMT, fmts[i]);
      @(posedge sys_clk);
      pixel_18bpp <= i[0];
      pixels(6);
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      check("pair_on", {16'h0000, chan_a.clk_on, chan_a.pair_on,
        chan_b.clk_on, chan_b.pair_on}, {16'h0000, 1'b1,
        fmt[A_WIDE_BIT], 3'h7, !fmt[LINK_BIT],
        !fmt[LINK_BIT] && fmt[B_WIDE_BIT], {3{!fmt[LINK_BIT]}}});
      $display("test format %h done", fmts[i]);
    end
    acc(1'b1, ADDR_INMODE, 8'h98);
    split = 1'b1;
    pixels(6);
    $display("test split done");
    // One low edge clears the core; the long low time a real part wants
    // is cut short here so that the run stays brief.
    @(posedge sys_clk);
    en <= 1'b0;
    fmt = 8'h00;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    check("lvds_oe", {24'h0, lvds_oe, chan_a.clk_on}, 26'h0);
    @(posedge sys_clk);
    en <= 1'b1;
    acc(1'b0, ADDR_OUTFMT, 8'h00);
    acc(1'b0, ADDR_PLL, 8'h00);
    check("lvds_oe", {25'h0, lvds_oe}, 26'h1);
    $display("test shutdown done");
    finish_test();
  end
endmodule : tb
